// File: drive_limits_pkg.sv
// constants, object addresses and carrier types for the drive enable and current limit block
package drive_limits_pkg;

   // clock and timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

   // object dictionary indices and sub-indices
   localparam logic [15:0] IDX_POLE_COUNT   = 16'h604d;
   localparam logic [15:0] IDX_OVERLOAD_LIM = 16'h6073;
   localparam logic [15:0] IDX_RATED_AMPS   = 16'h6075;
   localparam logic [15:0] IDX_MOTOR_REC    = 16'h6410;
   localparam logic [15:0] IDX_DRIVE_REC    = 16'h6510;
   localparam logic [7:0]  SUB_PLAIN        = 8'h00;
   localparam logic [7:0]  SUB_OVL_TIME     = 8'h03;
   localparam logic [7:0]  SUB_OVL_USAGE    = 8'h04;
   localparam logic [7:0]  SUB_ENABLE_SEL   = 8'h10;

   // reset values
   localparam logic [7:0]  POLE_COUNT_RST   = 8'h02;
   localparam logic [15:0] OVERLOAD_LIM_RST = 16'h07b0;
   localparam logic [31:0] RATED_AMPS_RST   = 32'h0000_0b36;
   localparam logic [15:0] OVL_TIME_RST     = 16'h07d0;
   localparam logic [15:0] ENABLE_SEL_RST   = 16'h0002;

   // value ranges and encodings
   localparam logic [7:0]  POLE_COUNT_MIN   = 8'h02;
   localparam logic [7:0]  POLE_COUNT_MAX   = 8'h80;
   localparam logic [15:0] OVL_TIME_MAX     = 16'h2710;
   localparam logic [15:0] ENABLE_SEL_MAX   = 16'h0002;
   localparam logic [15:0] ENABLE_SEL_PINS  = 16'h0000;
   localparam logic [15:0] ENABLE_SEL_SER   = 16'h0001;
   localparam logic [15:0] ENABLE_SEL_BUS   = 16'h0002;
   localparam logic [15:0] STOP_SPEED_RPM   = 16'h000a;
   localparam logic [9:0]  PERMILLE_FULL    = 10'h3e8;
   localparam logic [47:0] PERMILLE_SCALE   = 48'h0000_0000_03e8;

   // drive ratings, overridable at the top
   localparam logic [31:0] DRIVE_NOMINAL_MA = 32'h0000_1388;
   localparam logic [31:0] DRIVE_PEAK_MA    = 32'h0000_2710;

   typedef enum logic [1:0] {
      MODE_PROFILE_POS,
      MODE_PROFILE_VEL,
      MODE_TORQUE,
      MODE_OTHER
   } op_mode_e;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_RUN,
      ST_RAMP
   } stage_state_e;

   typedef struct packed {
      logic [15:0] index;
      logic [7:0]  subindex;
      logic        wr;
      logic        rd;
      logic [31:0] wdata;
   } od_req_s;

   typedef struct packed {
      logic        ack;
      logic        error;
      logic [31:0] rdata;
   } od_rsp_s;

endpackage : drive_limits_pkg

// File: overload_integrator.sv
// i2t utilisation integrator with overload clamp
`timescale 1ns/1ps
module overload_integrator (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   input  wire logic        ms_tick_i,
   input  wire logic        over_i,
   input  wire logic [15:0] time_ms_i,
   output logic      [9:0]  usage_o,
   output logic             clamp_o
);

   logic [9:0]  pending_reg;
   logic [9:0]  pending_next;
   logic        dir_up_reg;
   logic        dir_up_next;
   logic [15:0] frac_reg;
   logic [15:0] frac_next;
   logic [9:0]  usage_reg;
   logic [9:0]  usage_next;
   logic        clamp_reg;
   logic        clamp_next;

   // each ms spreads 1000 unit steps over cycles, one per cycle;
   // usage rises by one every time_ms steps, so it reaches 1000 after
   // exactly time_ms ms of overload without a divider
   always_comb begin
      pending_next = pending_reg;
      dir_up_next  = dir_up_reg;
      frac_next    = frac_reg;
      usage_next   = usage_reg;
      clamp_next   = clamp_reg;
      if (ms_tick_i) begin
         pending_next = drive_limits_pkg::PERMILLE_FULL;
         dir_up_next  = over_i;
      end else if (pending_reg != 10'h000) begin
         pending_next = pending_reg - 10'h001;
         if (frac_reg + 16'h0001 >= time_ms_i) begin
            frac_next = 16'h0000;
            if (dir_up_reg && usage_reg != drive_limits_pkg::PERMILLE_FULL)
               usage_next = usage_reg + 10'h001;
            else if (!dir_up_reg && usage_reg != 10'h000)
               usage_next = usage_reg - 10'h001;
         end else begin
            frac_next = frac_reg + 16'h0001;
         end
      end
      // clamp holds until the motor has fully cooled back to zero
      if (usage_reg == drive_limits_pkg::PERMILLE_FULL)
         clamp_next = 1'b1; // see R10
      else if (usage_reg == 10'h000)
         clamp_next = 1'b0;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pending_reg <= 10'h000;
         dir_up_reg  <= 1'b0;
         frac_reg    <= 16'h0000;
         usage_reg   <= 10'h000;
         clamp_reg   <= 1'b0;
      end else if (ce_i) begin
         pending_reg <= pending_next;
         dir_up_reg  <= dir_up_next;
         frac_reg    <= frac_next;
         usage_reg   <= usage_next;
         clamp_reg   <= clamp_next;
      end
   end

   assign usage_o = usage_reg;
   assign clamp_o = clamp_reg;

endmodule : overload_integrator

// File: drive_enable_limits.sv
// power stage enable gating and motor current limit parameters
//
// Overview of operation
// R1 - stage may run only while power-stage and controller enables are both set
// R2 - power-stage enable gates transistor triggers directly; losing it coasts (here it turns stage off and locks brake at once)
// R3 - profile modes: lost enable ramps down, stage off and brake below 10 rpm
// R4 - torque mode: lost enable switches stage off and locks brake at once
// R5 - enable source select 0 pins, 1 adds serial, 2 adds bus; resets to 2
// R6 - rated current in mA RMS, above drive nominal rejected, default 2870
// R7 - overload limit in per mille of rated, capped by drive peak, default 1968
// R8 - host sets rated current first and rewrites overload limit after it
// R9 - pole count integer 2 to 128, default 2, twice the pole pairs
// R10 - after overload time at overload current, clamp current to rated
// R11 - overload time in ms, range 0 to 10000, default 2000
// R12 - present i2t utilisation readable in per mille, read only
// R13 - controller enable is AND of both pins and selected serial/bus bit
`timescale 1ns/1ps
module drive_enable_limits #(
   parameter int          MS_CYCLES        = drive_limits_pkg::MS_CYCLES,
   parameter logic [31:0] DRIVE_NOMINAL_MA = drive_limits_pkg::DRIVE_NOMINAL_MA,
   parameter logic [31:0] DRIVE_PEAK_MA    = drive_limits_pkg::DRIVE_PEAK_MA
) (
   input  wire logic                      clk_sys_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      ce_i,
   input  wire logic                      en_power_stage_i,
   input  wire logic                      en_controller_i,
   input  wire logic                      serial_enable_i,
   input  wire logic                      bus_enable_i,
   input  wire logic [1:0]                op_mode_i,
   input  wire logic [15:0]               speed_rpm_i,
   input  wire logic [31:0]               motor_current_ma_i,
   input  wire drive_limits_pkg::od_req_s od_req_i,
   output drive_limits_pkg::od_rsp_s      od_rsp_o,
   output logic                           stage_on_o,
   output logic                           gate_enable_o,
   output logic                           brake_ramp_o,
   output logic                           brake_lock_o,
   output logic [31:0]                    current_limit_ma_o
);

   // address match for one object entry
   function automatic logic od_hit(input drive_limits_pkg::od_req_s req,
                                   input logic [15:0] idx,
                                   input logic [7:0]  sub);
      od_hit = (req.index == idx) && (req.subindex == sub);
   endfunction : od_hit

   // pin synchronisers, first stage read only by the second
   logic ps_meta_reg;
   logic ps_sync_reg;
   logic ctl_meta_reg;
   logic ctl_sync_reg;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ps_meta_reg  <= 1'b0;
         ps_sync_reg  <= 1'b0;
         ctl_meta_reg <= 1'b0;
         ctl_sync_reg <= 1'b0;
      end else if (ce_i) begin
         ps_meta_reg  <= en_power_stage_i;
         ps_sync_reg  <= ps_meta_reg;
         ctl_meta_reg <= en_controller_i;
         ctl_sync_reg <= ctl_meta_reg;
      end
   end

   // parameter registers
   logic [7:0]              pole_reg;
   logic [7:0]              pole_next;
   logic [15:0]             ovl_lim_reg;
   logic [15:0]             ovl_lim_next;
   logic [31:0]             rated_reg;
   logic [31:0]             rated_next;
   logic [15:0]             ovl_time_reg;
   logic [15:0]             ovl_time_next;
   logic [15:0]             en_sel_reg;
   logic [15:0]             en_sel_next;
   drive_limits_pkg::od_rsp_s rsp_reg;
   drive_limits_pkg::od_rsp_s rsp_next;
   logic [9:0]              usage;
   logic                    clamp;
   logic [47:0]             peak_scaled;

   assign peak_scaled = {16'h0000, DRIVE_PEAK_MA}
                        * drive_limits_pkg::PERMILLE_SCALE;

   // object access: one request per cycle, answered the next cycle;
   // an out-of-range write is refused and leaves the value untouched
   always_comb begin
      pole_next     = pole_reg;
      ovl_lim_next  = ovl_lim_reg;
      rated_next    = rated_reg;
      ovl_time_next = ovl_time_reg;
      en_sel_next   = en_sel_reg;
      rsp_next      = '0;
      if (od_req_i.wr || od_req_i.rd) begin
         rsp_next.ack = 1'b1;
         if (od_hit(od_req_i, drive_limits_pkg::IDX_POLE_COUNT,
                    drive_limits_pkg::SUB_PLAIN)) begin
            rsp_next.rdata = {24'h000000, pole_reg};
            if (od_req_i.wr) begin
               if (od_req_i.wdata >= {24'h000000, drive_limits_pkg::POLE_COUNT_MIN}
                   && od_req_i.wdata <= {24'h000000, drive_limits_pkg::POLE_COUNT_MAX})
                  pole_next = od_req_i.wdata[7:0]; // see R9
               else
                  rsp_next.error = 1'b1;
            end
         end else if (od_hit(od_req_i, drive_limits_pkg::IDX_OVERLOAD_LIM,
                             drive_limits_pkg::SUB_PLAIN)) begin
            rsp_next.rdata = {16'h0000, ovl_lim_reg};
            if (od_req_i.wr) begin
               // product of rated and limit must stay within peak current
               if (od_req_i.wdata[31:16] == 16'h0000
                   && rated_reg * od_req_i.wdata[15:0] <= peak_scaled)
                  ovl_lim_next = od_req_i.wdata[15:0]; // see R7, R8
               else
                  rsp_next.error = 1'b1;
            end
         end else if (od_hit(od_req_i, drive_limits_pkg::IDX_RATED_AMPS,
                             drive_limits_pkg::SUB_PLAIN)) begin
            rsp_next.rdata = rated_reg;
            if (od_req_i.wr) begin
               if (od_req_i.wdata <= DRIVE_NOMINAL_MA)
                  rated_next = od_req_i.wdata; // see R6
               else
                  rsp_next.error = 1'b1;
            end
         end else if (od_hit(od_req_i, drive_limits_pkg::IDX_MOTOR_REC,
                             drive_limits_pkg::SUB_OVL_TIME)) begin
            rsp_next.rdata = {16'h0000, ovl_time_reg};
            if (od_req_i.wr) begin
               if (od_req_i.wdata <= {16'h0000, drive_limits_pkg::OVL_TIME_MAX})
                  ovl_time_next = od_req_i.wdata[15:0]; // see R11
               else
                  rsp_next.error = 1'b1;
            end
         end else if (od_hit(od_req_i, drive_limits_pkg::IDX_MOTOR_REC,
                             drive_limits_pkg::SUB_OVL_USAGE)) begin
            rsp_next.rdata = {22'h000000, usage}; // see R12
            if (od_req_i.wr)
               rsp_next.error = 1'b1; // read-only object
         end else if (od_hit(od_req_i, drive_limits_pkg::IDX_DRIVE_REC,
                             drive_limits_pkg::SUB_ENABLE_SEL)) begin
            rsp_next.rdata = {16'h0000, en_sel_reg};
            if (od_req_i.wr) begin
               if (od_req_i.wdata <= {16'h0000, drive_limits_pkg::ENABLE_SEL_MAX})
                  en_sel_next = od_req_i.wdata[15:0]; // see R5
               else
                  rsp_next.error = 1'b1;
            end
         end else begin
            rsp_next.error = 1'b1; // unknown object
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pole_reg     <= drive_limits_pkg::POLE_COUNT_RST;
         ovl_lim_reg  <= drive_limits_pkg::OVERLOAD_LIM_RST;
         rated_reg    <= drive_limits_pkg::RATED_AMPS_RST;
         ovl_time_reg <= drive_limits_pkg::OVL_TIME_RST;
         en_sel_reg   <= drive_limits_pkg::ENABLE_SEL_RST; // see R5
         rsp_reg      <= '0;
      end else if (ce_i) begin
         pole_reg     <= pole_next;
         ovl_lim_reg  <= ovl_lim_next;
         rated_reg    <= rated_next;
         ovl_time_reg <= ovl_time_next;
         en_sel_reg   <= en_sel_next;
         rsp_reg      <= rsp_next;
      end
   end

   // effective controller enable from pins and selected source
   logic extra_en;
   logic ctl_enable;

   always_comb begin
      case (en_sel_reg)
         drive_limits_pkg::ENABLE_SEL_SER: extra_en = serial_enable_i;
         drive_limits_pkg::ENABLE_SEL_BUS: extra_en = bus_enable_i;
         default:                          extra_en = 1'b1;
      endcase
      ctl_enable = ps_sync_reg && ctl_sync_reg && extra_en; // see R1, R13
   end

   // stage state machine
   drive_limits_pkg::stage_state_e st_reg;
   drive_limits_pkg::stage_state_e st_next;
   logic                          gate_next;

   always_comb begin
      st_next = st_reg;
      case (st_reg)
         drive_limits_pkg::ST_OFF: begin
            if (ctl_enable)
               st_next = drive_limits_pkg::ST_RUN;
         end
         drive_limits_pkg::ST_RUN: begin
            if (!ps_sync_reg)
               st_next = drive_limits_pkg::ST_OFF; // see R2
            else if (!ctl_enable) begin
               if (op_mode_i == drive_limits_pkg::MODE_TORQUE)
                  st_next = drive_limits_pkg::ST_OFF; // see R4
               else
                  st_next = drive_limits_pkg::ST_RAMP; // see R3
            end
         end
         drive_limits_pkg::ST_RAMP: begin
            // a new enable mid-ramp waits until the stage is off first
            if (!ps_sync_reg
                || speed_rpm_i < drive_limits_pkg::STOP_SPEED_RPM)
               st_next = drive_limits_pkg::ST_OFF; // see R2, R3
         end
         default: st_next = drive_limits_pkg::ST_OFF;
      endcase
      // triggers follow the synchronised pin, not the sequencer alone
      gate_next = (st_next != drive_limits_pkg::ST_OFF)
                  && ps_sync_reg; // see R2
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st_reg        <= drive_limits_pkg::ST_OFF;
         stage_on_o    <= 1'b0;
         gate_enable_o <= 1'b0;
         brake_ramp_o  <= 1'b0;
         brake_lock_o  <= 1'b1;
      end else if (ce_i) begin
         st_reg        <= st_next;
         stage_on_o    <= st_next != drive_limits_pkg::ST_OFF;
         gate_enable_o <= gate_next;
         brake_ramp_o  <= st_next == drive_limits_pkg::ST_RAMP; // see R3
         brake_lock_o  <= st_next == drive_limits_pkg::ST_OFF; // see R4
      end
   end

   // millisecond tick for the i2t integrator
   logic [31:0] ms_cnt_reg;
   logic [31:0] ms_cnt_next;
   logic        ms_tick;

   always_comb begin
      ms_tick     = ms_cnt_reg == 32'(MS_CYCLES - 1);
      ms_cnt_next = ms_tick ? 32'h0000_0000 : ms_cnt_reg + 32'h0000_0001;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i)
         ms_cnt_reg <= 32'h0000_0000;
      else if (ce_i)
         ms_cnt_reg <= ms_cnt_next;
   end

   overload_integrator u_integrator (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .ms_tick_i (ms_tick),
      .over_i    (motor_current_ma_i > rated_reg),
      .time_ms_i (ovl_time_reg),
      .usage_o   (usage),
      .clamp_o   (clamp)
   );

   // current limit: overload level until the i2t time runs out
   logic [47:0] ovl_ma;
   logic [31:0] limit_next;

   always_comb begin
      ovl_ma     = (rated_reg * ovl_lim_reg) / drive_limits_pkg::PERMILLE_SCALE;
      limit_next = clamp ? rated_reg : ovl_ma[31:0]; // see R10
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i)
         current_limit_ma_o <= 32'h0000_0000;
      else if (ce_i)
         current_limit_ma_o <= limit_next;
   end

   assign od_rsp_o = rsp_reg;

endmodule : drive_enable_limits

// File: drive_enable_limits_asserts.sv
// checker for enable gating, stage sequencing and the object port
`timescale 1ns/1ps
module drive_enable_limits_asserts (
   input wire logic                      clk_sys_i,
   input wire logic                      rst_n_i,
   input wire logic                      ce_i,
   input wire logic                      en_power_stage_i,
   input wire logic                      en_controller_i,
   input wire logic                      serial_enable_i,
   input wire logic                      bus_enable_i,
   input wire logic [1:0]                op_mode_i,
   input wire logic [15:0]               speed_rpm_i,
   input wire logic [31:0]               motor_current_ma_i,
   input wire drive_limits_pkg::od_req_s od_req_i,
   input wire drive_limits_pkg::od_rsp_s od_rsp_o,
   input wire logic                      stage_on_o,
   input wire logic                      gate_enable_o,
   input wire logic                      brake_ramp_o,
   input wire logic                      brake_lock_o,
   input wire logic [31:0]               current_limit_ma_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   a_ack_one_cycle: assert property (
      ce_i && (od_req_i.wr || od_req_i.rd) |=> od_rsp_o.ack)
      else $error("no answer one cycle after a request");
   a_rsp_idle_zero: assert property (
      !od_rsp_o.ack |-> !od_rsp_o.error && od_rsp_o.rdata == 32'h0)
      else $error("response fields not zero outside ack");
   a_usage_write_err: assert property (
      ce_i && od_req_i.wr && od_req_i.index == 16'h6410
      && od_req_i.subindex == 8'h04 |=> od_rsp_o.error)
      else $error("write to usage not refused");
   a_stage_needs_both: assert property (
      $rose(stage_on_o) |-> $past(en_power_stage_i, 2)
      && $past(en_controller_i, 2))
      else $error("stage on without both enables");
   a_ps_cuts_gate: assert property (
      (ce_i && !en_power_stage_i) [*3] |=> !gate_enable_o)
      else $error("gate still on after power stage enable loss");
   a_brake_tracks_off: assert property (
      brake_lock_o == !stage_on_o)
      else $error("brake lock not tied to stage off");
   a_ramp_stops_slow: assert property (
      brake_ramp_o && ce_i && speed_rpm_i < 16'h000a |=> !stage_on_o)
      else $error("stage kept on below stop speed");
   a_torque_cuts_off: assert property (
      (ce_i && !en_controller_i && !brake_ramp_o
      && op_mode_i == drive_limits_pkg::MODE_TORQUE) [*4] |=> !stage_on_o)
      else $error("torque mode stage not off at once");
endmodule : drive_enable_limits_asserts

// File: od_master.sv
// fieldbus master model issuing object dictionary accesses
`timescale 1ns/1ps
module od_master (
   input  wire logic                      clk_sys_i,
   input  wire drive_limits_pkg::od_rsp_s od_rsp_i,
   output drive_limits_pkg::od_req_s      od_req_o
);
   initial od_req_o = '0;

   // strobe covers one taking edge; the answer stands until the next
   // rising edge, so the watcher samples it at the release falling edge
   task automatic access(input logic wr, input logic [15:0] idx,
                         input logic [7:0] sub, input logic [31:0] wd);
      @(negedge clk_sys_i);
      od_req_o = {idx, sub, wr, !wr, wd};
      @(negedge clk_sys_i);
      od_req_o.wr = 1'b0;
      od_req_o.rd = 1'b0;
      od_req_o.wdata = ~wd;  // released data must not look valid
   endtask : access
endmodule : od_master

// File: tb.sv
// self-checking bench for the drive enable and current limit block
`timescale 1ns/1ps
module tb;
   localparam int MS_SIM = 1100;  // short ms tick keeps the i2t run brief
   logic        clk_sys_i, rst_n_i, ps, ctl, ser, bus;
   logic        stage, gate, ramp, lock;
   logic [1:0]  mode;
   logic [15:0] speed;
   logic [31:0] cur, lim, v, seed;
   logic [33:0] e;
   logic [33:0] exp_q[$];
   int          errors = 0, n_checks = 0, cyc = 0, i;
   drive_limits_pkg::od_req_s req;
   drive_limits_pkg::od_rsp_s rsp;

   drive_enable_limits #(.MS_CYCLES(MS_SIM)) u_drive_enable_limits (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
      .en_power_stage_i(ps), .en_controller_i(ctl),
      .serial_enable_i(ser), .bus_enable_i(bus), .op_mode_i(mode),
      .speed_rpm_i(speed), .motor_current_ma_i(cur), .od_req_i(req),
      .od_rsp_o(rsp), .stage_on_o(stage), .gate_enable_o(gate),
      .brake_ramp_o(ramp), .brake_lock_o(lock), .current_limit_ma_o(lim));
   od_master u_od_master (.clk_sys_i(clk_sys_i), .od_rsp_i(rsp),
      .od_req_o(req));

   // 40 MHz system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0 && exp_q.size() == 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   // note the expected answer, then let the master issue the access
   task automatic acc(input logic wr, input logic [15:0] idx,
      input logic [7:0] sub, input logic [31:0] wd, input logic err,
      input logic [31:0] exp);
      exp_q.push_back({!err, err, exp});
      u_od_master.access(wr, idx, sub, wd);
   endtask : acc

   // bounded wait for the stage to reach a level
   task automatic wait_stage(input logic lvl);
      int n;
      n = 0;
      while (stage !== lvl && n < 16) begin
         @(negedge clk_sys_i);
         n++;
      end
      check({31'h0, stage}, {31'h0, lvl});
   endtask : wait_stage

   // answer watcher: data only compared when no refusal is expected;
   // sampled mid-cycle, away from the edge that launches the answer
   always @(negedge clk_sys_i) begin
      if (rsp.ack === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h1_0000_0000;
         check({31'h0, rsp.error}, {31'h0, e[32]});
         if (e[33])
            check(rsp.rdata, e[31:0]);
      end
   end

   // hang guard
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         results();
      end
   end

   initial begin
      rst_n_i = 1'b0;
      {ps, ctl, ser, bus, mode, speed, cur, seed} = '0;
      seed = 32'h1e;
      repeat (8) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      check(lim, 32'hb36 * 32'h7b0 / 32'h3e8);
      acc(0, 16'h604d, 8'h00, 0, 0, 32'h2);
      acc(0, 16'h6073, 8'h00, 0, 0, 32'h7b0);
      acc(0, 16'h6075, 8'h00, 0, 0, 32'hb36);
      acc(0, 16'h6410, 8'h03, 0, 0, 32'h7d0);
      acc(0, 16'h6410, 8'h04, 0, 0, 32'h0);
      acc(0, 16'h6510, 8'h10, 0, 0, 32'h2);
      acc(0, 16'h6000, 8'h00, 0, 1, 0);
      // rated first, then overload rewritten against it
      acc(1, 16'h6075, 8'h00, 32'h1389, 1, 0);
      acc(1, 16'h6075, 8'h00, 32'hbb8, 0, 32'hb36);
      acc(1, 16'h6073, 8'h00, 32'hd06, 1, 0);
      acc(1, 16'h6073, 8'h00, 32'hd05, 0, 32'h7b0);
      repeat (3) @(negedge clk_sys_i);
      check(lim, 32'hbb8 * 32'hd05 / 32'h3e8);
      acc(1, 16'h6073, 8'h00, 32'h7d0, 0, 32'hd05);
      acc(1, 16'h604d, 8'h00, 32'h1, 1, 0);
      acc(1, 16'h604d, 8'h00, 32'h81, 1, 0);
      acc(1, 16'h604d, 8'h00, 32'h80, 0, 32'h2);
      v = 32'h2 + rnd() % 32'h7f;
      acc(1, 16'h604d, 8'h00, v, 0, 32'h80);
      acc(0, 16'h604d, 8'h00, 0, 0, v);
      acc(1, 16'h6410, 8'h03, 32'h2711, 1, 0);
      acc(1, 16'h6410, 8'h03, 32'h2710, 0, 32'h7d0);
      acc(1, 16'h6410, 8'h03, 32'h1, 0, 32'h2710);
      acc(1, 16'h6410, 8'h04, 32'h0, 1, 0);
      acc(1, 16'h6510, 8'h10, 32'h3, 1, 0);
      // every enable source: 0 runs on the pins alone, 1 and 2 stay off until the selected bit joins in
      for (i = 0; i < 3; i++) begin
         acc(1, 16'h6510, 8'h10, 32'(i), 0, 32'((i + 2) % 3));
         {ps, ctl, ser, bus} = 4'hc;
         repeat (8) @(negedge clk_sys_i);
         check({31'h0, stage}, {31'h0, i == 0});
         {ser, bus} = 2'h3;
         wait_stage(1'b1);
         check({31'h0, gate}, 32'h1);
         ps = 1'b0;
         repeat (3) @(negedge clk_sys_i);
         check({29'h0, gate, stage, lock}, 32'h1);
      end
      // profile mode: ramp while fast, off below the stop speed
      speed = 16'h000a + 16'(rnd() % 32'h3e8);
      ps = 1'b1;
      wait_stage(1'b1);
      ctl = 1'b0;
      repeat (6) @(negedge clk_sys_i);
      check({30'h0, stage, ramp}, 32'h3);
      speed = 16'h0009;
      wait_stage(1'b0);
      check({30'h0, ramp, lock}, 32'h1);
      // torque mode: off and brake locked at once
      mode = 2'h2;
      ctl = 1'b1;
      wait_stage(1'b1);
      ctl = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      check({30'h0, stage, lock}, 32'h1);
      // overload just above rated until clamped, then back to rated
      check(lim, 32'h1770);
      cur = 32'hbb9;
      repeat (2600) @(negedge clk_sys_i);
      acc(0, 16'h6410, 8'h04, 0, 0, 32'h3e8);
      check(lim, 32'hbb8);
      cur = 32'hbb8;
      repeat (2600) @(negedge clk_sys_i);
      acc(0, 16'h6410, 8'h04, 0, 0, 32'h0);
      check(lim, 32'h1770);
      repeat (2) @(negedge clk_sys_i);
      results();
   end
endmodule : tb

bind drive_enable_limits drive_enable_limits_asserts
   u_drive_enable_limits_asserts (.*);
